// File: itt_timer.sv
`timescale 1ns/1ps

module itt_timer
(
   input  wire logic                       clk_sys_i,
   input  wire logic                       reset_n_i,
   input  wire logic                       psel_i,
   input  wire logic                       penable_i,
   input  wire logic                       pwrite_i,
   input  wire logic [itt_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic [itt_pkg::DATA_W-1:0] pwdata_i,
   input  wire logic [3:0]                 pstrb_i,
   output logic      [itt_pkg::DATA_W-1:0] prdata_o,
   output logic                            pready_o,
   output logic                            pslverr_o,
   input  wire logic                       sub_clk_i,
   input  wire itt_pkg::itt_pwr_t          power_mode_i,
   input  wire logic                       pin_func_en_i,
   output logic                            divided_clock_out_pin_o,
   output logic                            divided_clock_out_oe_o,
   output logic                            irq_o
);

   itt_pkg::itt_mode_t                 timer_mode_select;
   logic [7:0]                         timer_count_value;
   logic [itt_pkg::SYS_PSC_W-1:0]      system_prescaler;
   logic [itt_pkg::SUB_PSC_W-1:0]      subclock_prescaler;
   logic                               sub_meta;
   logic                               sub_sync;
   logic                               sub_prev;
   logic                               sub_edge;
   logic                               overflow_request_flag;
   logic                               overflow_irq_enable;
   logic [itt_pkg::DATA_W-1:0]         rd_data;
   logic                               rd_err;

   logic                               setup_ph;
   logic                               access_ph;
   logic                               wr_ok;
   logic                               hit_mode;
   logic                               hit_count;
   logic                               hit_status;
   logic                               hit_enable;
   logic                               hit_clear;
   logic                               hit_any;
   logic                               count_blocked;

   logic                               run_interval;
   logic                               run_timebase;
   logic                               tb_clear;
   logic                               sys_tick;
   logic                               sub_tick;
   logic                               count_tick;
   logic                               overflow;
   logic                               sys_wave;
   logic                               sub_wave;
   logic                               next_pin;
   logic                               flag_clear;

   // ---------------- apb decode ----------------
   assign setup_ph   = psel_i && !penable_i;
   assign access_ph  = psel_i && penable_i;
   assign hit_mode   = (paddr_i == itt_pkg::ADDR_MODE);
   assign hit_count  = (paddr_i == itt_pkg::ADDR_COUNT);
   assign hit_status = (paddr_i == itt_pkg::ADDR_IRQ_STATUS);
   assign hit_enable = (paddr_i == itt_pkg::ADDR_IRQ_ENABLE);
   assign hit_clear  = (paddr_i == itt_pkg::ADDR_IRQ_CLEAR);
   assign hit_any    = hit_mode || hit_count || hit_status || hit_enable || hit_clear;

   // counter reads refused while the cpu runs from the subclock
   assign count_blocked = hit_count && !pwrite_i
                          && (power_mode_i == itt_pkg::ITT_PWR_SUBACTIVE);

   assign wr_ok     = access_ph && pwrite_i && pstrb_i[0];
   assign pready_o  = 1'b1;
   assign pslverr_o = access_ph && rd_err;
   assign prdata_o  = rd_data;

   // read data and error are captured in the setup cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         rd_data <= '0;
         rd_err  <= 1'b0;
      end
      else if (setup_ph)
      begin
         rd_err  <= !hit_any || count_blocked
                    || (pwrite_i && (hit_count || hit_status));
         rd_data <= '0;
         if (!pwrite_i)
         begin
            if (hit_mode)
               rd_data <= {24'h000000, timer_mode_select};
            else if (hit_count && !count_blocked)
               rd_data <= {24'h000000, timer_count_value};
            else if (hit_status)
               rd_data <= {31'h00000000, overflow_request_flag};
            else if (hit_enable)
               rd_data <= {31'h00000000, overflow_irq_enable};
         end
      end
   end

   // ---------------- mode register ----------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         timer_mode_select <= itt_pkg::itt_mode_t'(itt_pkg::MODE_RESET);
      else if (wr_ok && hit_mode)
         timer_mode_select <= itt_pkg::itt_mode_t'(pwdata_i[7:0] | itt_pkg::MODE_RSVD_MASK);
   end

   // ---------------- interrupt enable ----------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         overflow_irq_enable <= itt_pkg::IRQ_RESET[itt_pkg::OVF_BIT];
      else if (wr_ok && hit_enable)
         overflow_irq_enable <= pwdata_i[itt_pkg::OVF_BIT];
   end

   // ---------------- system prescaler ----------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         system_prescaler <= '0;
      else
         system_prescaler <= system_prescaler + 1'b1;
   end

   // one-cycle tick when the low bits of the prescaler wrap
   function automatic logic div_tick(input logic [itt_pkg::SYS_PSC_W-1:0] psc,
                                     input int                            div);
      logic [itt_pkg::SYS_PSC_W-1:0] mask;
      mask = itt_pkg::SYS_PSC_W'(div - 1);
      return (psc & mask) == mask;
   endfunction

   always_comb
   begin
      unique case ({timer_mode_select.count_src_bit2, timer_mode_select.count_src_lo})
         3'b000: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_8192);
         3'b001: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_4096);
         3'b010: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_2048);
         3'b011: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_512);
         3'b100: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_256);
         3'b101: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_128);
         3'b110: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_32);
         3'b111: sys_tick = div_tick(system_prescaler, itt_pkg::SYS_DIV_8);
      endcase
   end

   // ---------------- subclock synchroniser ----------------
   // the subclock is asynchronous to the system clock
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         sub_meta <= 1'b0;
         sub_sync <= 1'b0;
         sub_prev <= 1'b0;
      end
      else
      begin
         sub_meta <= sub_clk_i;
         sub_sync <= sub_meta;
         sub_prev <= sub_sync;
      end
   end

   assign sub_edge = sub_sync && !sub_prev;

   // ---------------- subclock prescaler ----------------
   assign tb_clear = timer_mode_select.timebase_mode_sel
                     && timer_mode_select.count_src_bit2;

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         subclock_prescaler <= '0;
      else if (tb_clear)
         subclock_prescaler <= '0;
      else if (sub_edge)
         subclock_prescaler <= subclock_prescaler + 1'b1;
   end

   function automatic logic sub_div_tick(input logic [itt_pkg::SUB_PSC_W-1:0] psc,
                                         input int                            ticks);
      logic [itt_pkg::SUB_PSC_W-1:0] mask;
      mask = itt_pkg::SUB_PSC_W'(ticks - 1);
      return (psc & mask) == mask;
   endfunction

   always_comb
   begin
      unique case (timer_mode_select.count_src_lo)
         2'b00: sub_tick = sub_edge && sub_div_tick(subclock_prescaler, itt_pkg::TB_TICKS_0);
         2'b01: sub_tick = sub_edge && sub_div_tick(subclock_prescaler, itt_pkg::TB_TICKS_1);
         2'b10: sub_tick = sub_edge && sub_div_tick(subclock_prescaler, itt_pkg::TB_TICKS_2);
         2'b11: sub_tick = sub_edge && sub_div_tick(subclock_prescaler, itt_pkg::TB_TICKS_3);
      endcase
   end

   // ---------------- counter ----------------
   assign run_interval = (power_mode_i == itt_pkg::ITT_PWR_ACTIVE)
                         || (power_mode_i == itt_pkg::ITT_PWR_SLEEP);
   assign run_timebase = (power_mode_i != itt_pkg::ITT_PWR_STANDBY);

   always_comb
   begin
      if (!timer_mode_select.timebase_mode_sel)
         count_tick = run_interval && sys_tick;
      else if (!timer_mode_select.count_src_bit2)
         count_tick = run_timebase && sub_tick;
      else
         count_tick = 1'b0;
   end

   assign overflow = count_tick && (timer_count_value == itt_pkg::COUNT_MAX);

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         timer_count_value <= itt_pkg::COUNT_RESET;
      else if (tb_clear)
         timer_count_value <= itt_pkg::COUNT_RESET;
      else if (count_tick)
         timer_count_value <= timer_count_value + 1'b1;
   end

   // ---------------- overflow flag and interrupt ----------------
   // a fresh overflow wins over a clear in the same cycle
   assign flag_clear = wr_ok && hit_clear && !pwdata_i[itt_pkg::OVF_BIT];

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         overflow_request_flag <= itt_pkg::IRQ_RESET[itt_pkg::OVF_BIT];
      else if (overflow)
         overflow_request_flag <= 1'b1;
      else if (flag_clear)
         overflow_request_flag <= 1'b0;
   end

   assign irq_o = overflow_request_flag && overflow_irq_enable;

   // ---------------- clock output ----------------
   always_comb
   begin
      unique case (timer_mode_select.out_div_sel)
         2'b00:
         begin
            sys_wave = system_prescaler[$clog2(itt_pkg::OUT_DIV_32)-1];
            sub_wave = subclock_prescaler[$clog2(itt_pkg::OUT_DIV_32)-1];
         end
         2'b01:
         begin
            sys_wave = system_prescaler[$clog2(itt_pkg::OUT_DIV_16)-1];
            sub_wave = subclock_prescaler[$clog2(itt_pkg::OUT_DIV_16)-1];
         end
         2'b10:
         begin
            sys_wave = system_prescaler[$clog2(itt_pkg::OUT_DIV_8)-1];
            sub_wave = subclock_prescaler[$clog2(itt_pkg::OUT_DIV_8)-1];
         end
         2'b11:
         begin
            sys_wave = system_prescaler[$clog2(itt_pkg::OUT_DIV_4)-1];
            sub_wave = subclock_prescaler[$clog2(itt_pkg::OUT_DIV_4)-1];
         end
      endcase
   end

   always_comb
   begin
      if (!pin_func_en_i)
         next_pin = 1'b0;
      else if (timer_mode_select.out_source_sel)
         next_pin = sub_wave && (run_interval
                    || (power_mode_i == itt_pkg::ITT_PWR_SUBACTIVE));
      else
         next_pin = sys_wave && run_interval;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         divided_clock_out_pin_o <= 1'b0;
         divided_clock_out_oe_o  <= 1'b0;
      end
      else
      begin
         divided_clock_out_pin_o <= next_pin;
         divided_clock_out_oe_o  <= pin_func_en_i;
      end
   end

endmodule

// File: itt_pkg.sv
package itt_pkg;

   // apb geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;

   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_MODE       = 16'hFFB0;
   localparam logic [15:0] IDX_COUNT      = 16'hFFB1;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFB4;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'hFFB5;
   localparam logic [15:0] IDX_IRQ_CLEAR  = 16'hFFB6;

   localparam logic [ADDR_W-1:0] ADDR_MODE       = ADDR_W'({IDX_MODE, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_COUNT      = ADDR_W'({IDX_COUNT, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'({IDX_IRQ_STATUS, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = ADDR_W'({IDX_IRQ_ENABLE, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = ADDR_W'({IDX_IRQ_CLEAR, 2'b00});

   // reset values and fixed bits
   localparam logic [7:0] MODE_RESET     = 8'h10;
   localparam logic [7:0] MODE_RSVD_MASK = 8'h10;
   localparam logic [7:0] COUNT_RESET    = 8'h00;
   localparam logic [7:0] COUNT_MAX      = 8'hFF;
   localparam logic [7:0] IRQ_RESET      = 8'h00;

   // interrupt status / enable / clear layout
   localparam int OVF_BIT = 0;

   // mode register layout, msb first
   typedef struct packed {
      logic       out_source_sel;
      logic [1:0] out_div_sel;
      logic       reserved;
      logic       timebase_mode_sel;
      logic       count_src_bit2;
      logic [1:0] count_src_lo;
   } itt_mode_t;

   typedef enum logic [2:0] {
      ITT_PWR_ACTIVE,
      ITT_PWR_SLEEP,
      ITT_PWR_WATCH,
      ITT_PWR_SUBACTIVE,
      ITT_PWR_SUBSLEEP,
      ITT_PWR_STANDBY
   } itt_pwr_t;

   // system prescaler divide ratios
   localparam int SYS_PSC_W = 13;
   localparam int SYS_DIV_8192 = 8192;
   localparam int SYS_DIV_4096 = 4096;
   localparam int SYS_DIV_2048 = 2048;
   localparam int SYS_DIV_512  = 512;
   localparam int SYS_DIV_256  = 256;
   localparam int SYS_DIV_128  = 128;
   localparam int SYS_DIV_32   = 32;
   localparam int SYS_DIV_8    = 8;

   // clock output divide ratios, shared by both sources
   localparam int OUT_DIV_32 = 32;
   localparam int OUT_DIV_16 = 16;
   localparam int OUT_DIV_8  = 8;
   localparam int OUT_DIV_4  = 4;

   // time base: overflow periods in microseconds
   localparam longint SUB_CLK_HZ     = 32768;
   localparam longint US_PER_S       = 1000000;
   localparam longint COUNTS_PER_OVF = 256;
   localparam longint TB_PERIOD_0_US = 1000000;
   localparam longint TB_PERIOD_1_US = 500000;
   localparam longint TB_PERIOD_2_US = 250000;
   localparam longint TB_PERIOD_3_US = 31250;

   // subclock periods per counter increment
   localparam int TB_TICKS_0 = int'(TB_PERIOD_0_US * SUB_CLK_HZ / (US_PER_S * COUNTS_PER_OVF));
   localparam int TB_TICKS_1 = int'(TB_PERIOD_1_US * SUB_CLK_HZ / (US_PER_S * COUNTS_PER_OVF));
   localparam int TB_TICKS_2 = int'(TB_PERIOD_2_US * SUB_CLK_HZ / (US_PER_S * COUNTS_PER_OVF));
   localparam int TB_TICKS_3 = int'(TB_PERIOD_3_US * SUB_CLK_HZ / (US_PER_S * COUNTS_PER_OVF));
   localparam int SUB_PSC_W  = 7;

endpackage

// File: itt_timer_sva.sv
`timescale 1ns/1ps
module itt_timer_sva
(
   input wire logic                       clk_sys_i,
   input wire logic                       reset_n_i,
   input wire logic                       psel_i,
   input wire logic                       penable_i,
   input wire logic                       pwrite_i,
   input wire logic [itt_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [itt_pkg::DATA_W-1:0] pwdata_i,
   input wire logic [3:0]                 pstrb_i,
   input wire logic [itt_pkg::DATA_W-1:0] prdata_o,
   input wire logic                       pready_o,
   input wire logic                       pslverr_o,
   input wire logic                       sub_clk_i,
   input wire itt_pkg::itt_pwr_t          power_mode_i,
   input wire logic                       pin_func_en_i,
   input wire logic                       divided_clock_out_pin_o,
   input wire logic                       divided_clock_out_oe_o,
   input wire logic                       irq_o
);
   logic en_shadow;
   logic acc;
   logic rd_cnt;
   logic mapped;
   logic gated;
   assign acc = psel_i && penable_i;
   assign rd_cnt = acc && !pwrite_i && paddr_i == itt_pkg::ADDR_COUNT;
   assign mapped = paddr_i inside {itt_pkg::ADDR_MODE, itt_pkg::ADDR_COUNT,
      itt_pkg::ADDR_IRQ_STATUS, itt_pkg::ADDR_IRQ_ENABLE, itt_pkg::ADDR_IRQ_CLEAR};
   assign gated = power_mode_i inside {itt_pkg::ITT_PWR_WATCH, itt_pkg::ITT_PWR_SUBSLEEP,
      itt_pkg::ITT_PWR_STANDBY};
   // software view of the overflow enable bit
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         en_shadow <= 1'b0;
      else if (acc && pwrite_i && pstrb_i[0] && paddr_i == itt_pkg::ADDR_IRQ_ENABLE)
         en_shadow <= pwdata_i[0];
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   property p_rst_quiet;
      disable iff (1'b0) !reset_n_i |=> !irq_o && !divided_clock_out_pin_o && !divided_clock_out_oe_o;
   endproperty
   property p_ready;       acc |-> pready_o; endproperty
   property p_rsvd;
      acc && !pwrite_i && paddr_i == itt_pkg::ADDR_MODE |-> prdata_o[4] && prdata_o[31:8] == 24'h0;
   endproperty
   property p_count_ro;    acc && pwrite_i && paddr_i == itt_pkg::ADDR_COUNT |-> pslverr_o; endproperty
   property p_unmapped;    acc && !mapped |-> pslverr_o; endproperty
   property p_sub_read;    rd_cnt && power_mode_i == itt_pkg::ITT_PWR_SUBACTIVE |-> pslverr_o; endproperty
   property p_act_read;    rd_cnt && power_mode_i == itt_pkg::ITT_PWR_ACTIVE |-> !pslverr_o; endproperty
   property p_irq_en;      irq_o |-> en_shadow; endproperty
   property p_gated_pin;   gated [*3] |-> !divided_clock_out_pin_o; endproperty
   property p_oe_follow;
      $changed(pin_func_en_i) |=> divided_clock_out_oe_o == $past(pin_func_en_i);
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
   a_ready: assert property (p_ready) else $error("access not ready");
   a_rsvd: assert property (p_rsvd) else $error("mode bit 4 not one");
   a_count_ro: assert property (p_count_ro) else $error("count write accepted");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
   a_sub_read: assert property (p_sub_read) else $error("count read in subactive");
   a_act_read: assert property (p_act_read) else $error("count read refused");
   a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
   a_gated_pin: assert property (p_gated_pin) else $error("clock out in gated mode");
   a_oe_follow: assert property (p_oe_follow) else $error("oe not following");
   c_irq: cover property ($rose(irq_o));
   c_err: cover property (acc && pslverr_o);
   c_pin: cover property ($rose(divided_clock_out_pin_o));
endmodule
bind itt_timer itt_timer_sva u_itt_timer_sva (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .sub_clk_i(sub_clk_i), .power_mode_i(power_mode_i),
   .pin_func_en_i(pin_func_en_i), .divided_clock_out_pin_o(divided_clock_out_pin_o),
   .divided_clock_out_oe_o(divided_clock_out_oe_o), .irq_o(irq_o));

// File: tb_itt_timer.sv
`timescale 1ns/1ps
module tb_itt_timer;
   typedef struct {
      logic        wr;
      logic [19:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic        err;
   } itt_row_t;
   logic                clk = 1'b0;
   logic                reset_n = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [19:0]         paddr = 20'h0;
   logic [31:0]         pwdata = 32'h0;
   logic                sub_clk = 1'b0;
   itt_pkg::itt_pwr_t   power = itt_pkg::ITT_PWR_ACTIVE;
   logic                pin_func = 1'b0;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic                pin;
   logic                oe;
   logic                irq;
   int                  fail_count = 0;
   int                  tests_run = 0;
   int                  cyc = 0;
   int                  i;
   int                  n;
   int                  t0;
   logic [31:0]         rd;
   logic                er;
   logic [7:0]          c0;
   itt_row_t            rows[10];
   itt_timer u_itt_timer (.clk_sys_i(clk), .reset_n_i(reset_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .sub_clk_i(sub_clk), .power_mode_i(power), .pin_func_en_i(pin_func),
      .divided_clock_out_pin_o(pin), .divided_clock_out_oe_o(oe), .irq_o(irq));
   initial
   begin
      forever #50 clk = ~clk;
   end
   // 32.768 kHz, unrelated in phase to the system clock
   initial
   begin
      forever #15258.789 sub_clk = ~sub_clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   task automatic chk_rng(input int v, input int lo, input int hi, input string msg);
      chk(32'(v >= lo && v <= hi), 32'h1, msg);
   endtask
   task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do
      begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic toggles(input int span, output int cnt);
      logic p;
      cnt = 0;
      p = pin;
      repeat (span)
      begin
         @(posedge clk);
         if (pin !== p) cnt++;
         p = pin;
      end
   endtask
   task automatic complete_run;
      $display("tests %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #3000000;
      fail_count++;
      complete_run();
   end
   initial
   begin
      rows[0] = '{1'b1, itt_pkg::ADDR_MODE, 32'h00000000, 32'h00000000, 1'b0};
      rows[1] = '{1'b0, itt_pkg::ADDR_MODE, 32'h00000000, 32'h00000010, 1'b0};
      rows[2] = '{1'b1, itt_pkg::ADDR_MODE, 32'h000000EF, 32'h00000000, 1'b0};
      rows[3] = '{1'b0, itt_pkg::ADDR_MODE, 32'h00000000, 32'h000000FF, 1'b0};
      rows[4] = '{1'b0, itt_pkg::ADDR_COUNT, 32'h00000000, 32'h00000000, 1'b0};
      rows[5] = '{1'b1, itt_pkg::ADDR_COUNT, 32'h00000055, 32'h00000000, 1'b1};
      rows[6] = '{1'b0, 20'h3FEE0, 32'h00000000, 32'h00000000, 1'b1};
      rows[7] = '{1'b1, itt_pkg::ADDR_IRQ_STATUS, 32'h00000001, 32'h00000000, 1'b1};
      rows[8] = '{1'b0, itt_pkg::ADDR_IRQ_CLEAR, 32'h00000000, 32'h00000000, 1'b0};
      rows[9] = '{1'b0, itt_pkg::ADDR_IRQ_ENABLE, 32'h00000000, 32'h00000000, 1'b0};
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, itt_pkg::ADDR_MODE, 32'h0);
      chk(rd, 32'h10, "mode reset");
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      chk(rd, 32'h0, "count reset");
      apb(1'b0, itt_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'h0, "status reset");
      chk({31'h0, irq}, 32'h0, "irq reset");
      $display("test reset done");
      for (i = 0; i < 10; i++)
      begin
         apb(rows[i].wr, rows[i].addr, rows[i].wdata);
         chk({31'h0, er}, {31'h0, rows[i].err}, "response");
         if (!rows[i].wr && !rows[i].err) chk(rd, rows[i].exp, "read data");
      end
      $display("test table done");
      apb(1'b1, itt_pkg::ADDR_MODE, 32'h17);
      t0 = cyc;
      n = 0;
      do
      begin
         apb(1'b0, itt_pkg::ADDR_IRQ_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 1200);
      chk_rng(cyc - t0, 2040, 2062, "overflow period");
      chk({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, itt_pkg::ADDR_IRQ_ENABLE, 32'h1);
      chk({31'h0, irq}, 32'h1, "irq enabled");
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      chk({26'h0, rd[7:2]}, 32'h0, "count wrapped");
      apb(1'b1, itt_pkg::ADDR_IRQ_CLEAR, 32'h1);
      apb(1'b0, itt_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'h1, "flag kept");
      apb(1'b1, itt_pkg::ADDR_IRQ_CLEAR, 32'h0);
      apb(1'b0, itt_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'h0, "flag cleared");
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test interval done");
      power <= itt_pkg::ITT_PWR_STANDBY;
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      c0 = rd[7:0];
      repeat (100) @(posedge clk);
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      chk(rd, {24'h0, c0}, "interval halted");
      power <= itt_pkg::ITT_PWR_SUBACTIVE;
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      chk({31'h0, er}, 32'h1, "subactive read");
      power <= itt_pkg::ITT_PWR_ACTIVE;
      $display("test power done");
      pin_func <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         apb(1'b1, itt_pkg::ADDR_MODE, {24'h0, 1'b0, i[1:0], 5'h17});
         repeat (4) @(posedge clk);
         toggles(64, n);
         chk(32'(n), 32'(4 << i), "system clock out");
      end
      chk({31'h0, oe}, 32'h1, "oe on");
      power <= itt_pkg::ITT_PWR_WATCH;
      repeat (4) @(posedge clk);
      toggles(64, n);
      chk(32'(n), 32'h0, "system out gated");
      pin_func <= 1'b0;
      repeat (2) @(posedge clk);
      chk({31'h0, oe}, 32'h0, "oe off");
      pin_func <= 1'b1;
      $display("test clock out done");
      apb(1'b1, itt_pkg::ADDR_MODE, 32'hFB);
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      c0 = rd[7:0];
      toggles(2441, n);
      chk(32'(n), 32'h0, "sub out gated in watch");
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      // 8-bit difference so a wrap of the counter is harmless
      c0 = rd[7:0] - c0;
      chk_rng(int'(c0), 1, 3, "time base counts");
      power <= itt_pkg::ITT_PWR_SUBACTIVE;
      toggles(2441, n);
      chk_rng(n, 3, 5, "sub clock out");
      power <= itt_pkg::ITT_PWR_STANDBY;
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      c0 = rd[7:0];
      repeat (2441) @(posedge clk);
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      chk(rd, {24'h0, c0}, "time base halted");
      $display("test time base done");
      // reset in mid-run: registers return to their reset values and counting restarts
      power <= itt_pkg::ITT_PWR_ACTIVE;
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq after reset");
      apb(1'b0, itt_pkg::ADDR_MODE, 32'h0);
      chk(rd, 32'h10, "mode after reset");
      repeat (8200) @(posedge clk);
      apb(1'b0, itt_pkg::ADDR_COUNT, 32'h0);
      chk(rd, 32'h1, "count restarted");
      $display("test mid-run reset done");
      complete_run();
   end
endmodule
